//--- bfhs_sequencer.sv
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Upper switch on for on-time, lower on for rest; fixed clock paces cycles.
// - Upper duty capped at 80 percent of the switching period.
// - After enable wait a fixed delay, then soft start; no discharge of pre-bias.
// - Supply lockout shuts down; on recovery run refresh then soft start.
// - Upper current limit ends the running on-time at once.
// - Upper counter +2 per limited, -1 per normal cycle; trip at 6.
// - Over-current shutdown: upper off, lower on until zero current, then power-good low.
// - Upper trip waits six soft-start durations, refresh, then soft start.
// - Upper limit watched from soft start on, ignored in shutdown and hiccup.
// - Lower limit hit skips next upper pulse; resumes after a clean cycle.
// - Lower counter +2 per limited, -1 per normal cycle; trip at 8.
// - Lower trip waits four soft-start durations, refresh, then soft start.
// - Lower limit watched from soft start on, ignored in shutdown and hiccup.
// - Debounced undervoltage: shutdown sequence, then five durations, refresh, retry.
// - Undervoltage watched only after power-good delay following soft start.
// - Debounced overvoltage: power-good low, upper off, lower on, reference zero; lower held on only while feedback stays over.
// - Negative lower limit in overvoltage: lower off at least 640 ns.
// - Overvoltage waits eight durations, refresh, soft start; watched from soft start.
// - Overvoltage ignored in shutdown and hiccup.
// - Over-temperature from soft start shuts all down; recovery restarts soft start.
// - Power-good released only fault-free and after 100 us in window.
// - Power-good low after enable low 1 us; immediately on supply lockout.
// - Undervoltage comparator debounced 2 us.
// - Overvoltage comparator debounced 1 us.
module bfhs_sequencer #(
	parameter int SS_CYCLES = bfhs_pkg::SS_CYC_DEF
) (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Enable, supply and temperature inputs
	input  wire logic        enable_i,
	input  wire logic        supply_low_i,
	input  wire logic        supply_good_i,
	input  wire logic        temp_high_i,
	input  wire logic        temp_recovered_i,
	// Current and feedback comparators
	input  wire logic        upper_current_limit_i,
	input  wire logic        lower_current_limit_i,
	input  wire logic        lower_negative_limit_i,
	input  wire logic        feedback_under_i,
	input  wire logic        feedback_over_i,
	input  wire logic        feedback_window_i,
	input  wire logic        zero_current_detect_i,
	// Switch commands and reference
	output logic             upper_switch_on_o,
	output logic             lower_switch_on_o,
	output logic             reference_zero_o,
	output logic             soft_start_o,
	// Open-drain power good
	input  wire logic        power_good_out_i,
	output logic             power_good_out_o,
	output logic             power_good_out_oe_o
);
	import bfhs_pkg::*;

	localparam logic [23:0] SS_LAST = 24'(SS_CYCLES - 1);
	localparam int          SS_STEP_I = (SS_CYCLES / PERIOD_CYC > 1) ? SS_CYCLES / PERIOD_CYC : 1;
	localparam logic [15:0] SS_STEP_LAST = 16'(SS_STEP_I - 1);

	typedef struct packed {
		bfhs_state_t         state;
		logic [NUM_IN-1:0]   in_s1;
		logic [NUM_IN-1:0]   in_s2;
		logic [5:0]          per;
		logic [23:0]         tmr;
		logic [15:0]         ss_step;
		logic [5:0]          ss_lim;
		logic                hs_cut;
		logic                ls_hit;
		logic                skip;
		logic                hs_fired;
		logic [2:0]          hs_cnt;
		logic [3:0]          ls_cnt;
		logic [3:0]          hic_left;
		logic [2:0]          cause;
		logic [7:0]          uv_cnt;
		logic [7:0]          ov_cnt;
		logic [7:0]          en_cnt;
		logic [11:0]         win_cnt;
		logic                armed;
		logic                pg;
		logic [3:0]          neg_cnt;
		logic                lock_seen;
		logic                hs;
		logic                ls;
		logic                ref_zero;
		logic                ctrl_en;
		logic [5:0]          ontime;
		logic                ack;
		logic [31:0]         dat;
	} bfhs_regs_t;

	bfhs_regs_t r;
	bfhs_regs_t n;

	// Next-state logic for the whole block
	always_comb
	begin
		logic        en, sup_low, sup_good, u_lim, l_lim, neg_lim;
		logic        fb_under, fb_over, fb_win, zc, t_high, t_rec;
		logic        cyc_end, hs_cut_now, ls_hit_now, ss_start, trip;
		logic [3:0]  hs_sum;
		logic [4:0]  ls_sum;
		logic [5:0]  on_lim;
		logic [31:0] rd;
		n          = r;
		en         = r.in_s2[IN_EN];
		sup_low    = r.in_s2[IN_SLOW];
		sup_good   = r.in_s2[IN_SGOOD];
		u_lim      = r.in_s2[IN_ULIM];
		l_lim      = r.in_s2[IN_LLIM];
		neg_lim    = r.in_s2[IN_NEG];
		fb_under   = r.in_s2[IN_UNDER];
		fb_over    = r.in_s2[IN_OVER];
		fb_win     = r.in_s2[IN_WIN];
		zc         = r.in_s2[IN_ZC];
		t_high     = r.in_s2[IN_THOT];
		t_rec      = r.in_s2[IN_TREC];
		cyc_end    = (r.per == PER_LAST);
		hs_cut_now = r.hs_cut | (r.hs & u_lim);
		ls_hit_now = r.ls_hit | l_lim;
		hs_sum     = {1'b0, r.hs_cnt} + 4'h2;
		ls_sum     = {1'b0, r.ls_cnt} + 5'h02;
		ss_start   = 1'b0;
		trip       = 1'b0;
		on_lim     = 6'h00;
		rd         = 32'h0000_0000;

		// Two-stage synchronisers for all pins except the Wishbone bus
		n.in_s1 = {power_good_out_i, temp_recovered_i, temp_high_i, zero_current_detect_i,
			feedback_window_i, feedback_over_i, feedback_under_i, lower_negative_limit_i,
			lower_current_limit_i, upper_current_limit_i, supply_good_i, supply_low_i, enable_i};
		n.in_s2 = r.in_s1;

		// Free-running switching period and state timer
		n.per = cyc_end ? 6'h00 : r.per + 6'h01;
		n.tmr = r.tmr + 24'h00_0001;

		// Wishbone: one ack per request, unmapped reads return zero
		n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
		rd[3:0]                     = r.state;
		rd[STAT_PG_BIT]             = r.pg;
		rd[STAT_PIN_BIT]            = r.in_s2[IN_PGPIN];
		rd[STAT_CAUSE_LSB +: 3]     = r.cause;
		rd[STAT_LOCK_BIT]           = r.lock_seen;
		if (n.ack)
		begin
			n.dat = 32'h0000_0000;
			unique case (wb_adr_i)
				REG_CTRL:   n.dat[0] = r.ctrl_en;
				REG_ONTIME: n.dat[5:0] = r.ontime;
				REG_STATUS: n.dat = rd;
				REG_COUNT:
				begin
					n.dat[2:0]                = r.hs_cnt;
					n.dat[CNT_LS_LSB +: 4]    = r.ls_cnt;
					n.dat[CNT_HIC_LSB +: 4]   = r.hic_left;
				end
				default:    n.dat = 32'h0000_0000;
			endcase
		end
		// Writes land at the edge where the master samples ack, while it still holds the request
		if (r.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0])
		begin
			if (wb_adr_i == REG_CTRL)
				n.ctrl_en = wb_dat_i[0];
			if (wb_adr_i == REG_ONTIME)
				n.ontime = wb_dat_i[5:0];
		end

		// Enable-low qualification timer
		if (en)
			n.en_cnt = 8'h00;
		else if (r.en_cnt != EN_LOW_CYC)
			n.en_cnt = r.en_cnt + 8'h01;

		// Sequencer
		unique case (r.state)
			ST_OFF:
			begin
				n.tmr = 24'h00_0000;
				if (en && sup_good && r.ctrl_en)
				begin
					n.state     = r.lock_seen ? ST_REFRESH : ST_POST_EN;
					n.lock_seen = 1'b0;
				end
			end
			ST_POST_EN:
				if (r.tmr == RST_LAST)
					ss_start = 1'b1;
			ST_REFRESH:
				if (r.tmr == REFRESH_LAST)
					ss_start = 1'b1;
			ST_SS, ST_RUN:
			begin
				if (r.hs)
					n.hs_fired = 1'b1;
				n.hs_cut = hs_cut_now;
				n.ls_hit = ls_hit_now;
				// Cycle end: over-current bookkeeping
				if (cyc_end)
				begin
					n.hs_cut   = 1'b0;
					n.ls_hit   = 1'b0;
					n.hs_fired = 1'b0;
					n.skip     = ls_hit_now;
					if (!r.skip && hs_cut_now)
						n.hs_cnt = hs_sum[2:0];
					else if (!r.skip && r.hs_cnt != 3'h0)
						n.hs_cnt = r.hs_cnt - 3'h1;
					if (ls_hit_now)
						n.ls_cnt = ls_sum[3:0];
					else if (!r.skip && r.ls_cnt != 4'h0)
						n.ls_cnt = r.ls_cnt - 4'h1;
				end
				n.ov_cnt = fb_over ? r.ov_cnt + 8'h01 : 8'h00;
				n.uv_cnt = (fb_under && r.armed) ? r.uv_cnt + 8'h01 : 8'h00;
				if (r.state == ST_SS)
				begin
					// Ramp the on-time limit across the soft-start duration
					n.ss_step = r.ss_step + 16'h0001;
					if (r.ss_step == SS_STEP_LAST)
					begin
						n.ss_step = 16'h0000;
						if (r.ss_lim < DUTY_MAX_CYC)
							n.ss_lim = r.ss_lim + 6'h01;
					end
					if (r.tmr == SS_LAST)
					begin
						n.state   = ST_RUN;
						n.win_cnt = 12'h000;
					end
				end
				else
				begin
					// Power good after the feedback stays in window
					if (!fb_win)
						n.win_cnt = 12'h000;
					else if (r.win_cnt != PG_DELAY_CYC)
						n.win_cnt = r.win_cnt + 12'h001;
					n.pg = (n.win_cnt == PG_DELAY_CYC);
					if (n.pg)
						n.armed = 1'b1;
				end
				// Faults, lowest priority first
				if (r.armed && fb_under && r.uv_cnt == UV_LAST)
				begin
					trip    = 1'b1;
					n.cause = CAUSE_UV;
				end
				if (cyc_end && ls_hit_now && ls_sum >= LS_TRIP)
				begin
					trip    = 1'b1;
					n.cause = CAUSE_LS;
				end
				if (cyc_end && !r.skip && hs_cut_now && hs_sum >= HS_TRIP)
				begin
					trip    = 1'b1;
					n.cause = CAUSE_HS;
				end
				if (trip)
				begin
					n.state  = ST_SHUTDOWN;
					n.hs_cnt = 3'h0;
					n.ls_cnt = 4'h0;
				end
				if (fb_over && r.ov_cnt == OV_LAST)
				begin
					n.state    = ST_OVP;
					n.pg       = 1'b0;
					n.tmr      = 24'h00_0000;
					n.hic_left = HIC_OV;
					n.neg_cnt  = 4'h0;
					n.cause    = CAUSE_OV;
				end
				if (t_high)
				begin
					n.state = ST_THERMAL;
					n.pg    = 1'b0;
					n.cause = CAUSE_OT;
				end
			end
			ST_SHUTDOWN:
			begin
				n.tmr = 24'h00_0000;
				if (zc)
				begin
					n.state    = ST_HICCUP;
					n.pg       = 1'b0;
					n.hic_left = (r.cause == CAUSE_HS) ? HIC_HS :
						(r.cause == CAUSE_LS) ? HIC_LS : HIC_UV;
				end
			end
			ST_HICCUP, ST_OVP:
			begin
				// Negative current blanking of the lower switch
				if (r.state == ST_OVP && neg_lim && r.ls)
					n.neg_cnt = NEG_OFF_CYC;
				else if (r.neg_cnt != 4'h0)
					n.neg_cnt = r.neg_cnt - 4'h1;
				// Hiccup counted in whole soft-start durations
				if (r.tmr == SS_LAST)
				begin
					n.tmr = 24'h00_0000;
					if (r.hic_left == 4'h1)
						n.state = ST_REFRESH;
					else
						n.hic_left = r.hic_left - 4'h1;
				end
			end
			ST_THERMAL:
				if (t_rec && !t_high)
					ss_start = 1'b1;
			default:
				n.state = ST_OFF;
		endcase

		// Soft-start entry clears the fault counters and filters, not the cause
		if (ss_start)
		begin
			n.state    = ST_SS;
			n.tmr      = 24'h00_0000;
			n.per      = 6'h00;
			n.ss_lim   = 6'h01;
			n.ss_step  = 16'h0000;
			n.hs_cnt   = 3'h0;
			n.ls_cnt   = 4'h0;
			n.hs_cut   = 1'b0;
			n.ls_hit   = 1'b0;
			n.skip     = 1'b0;
			n.hs_fired = 1'b0;
			n.armed    = 1'b0;
			n.win_cnt  = 12'h000;
			n.uv_cnt   = 8'h00;
			n.ov_cnt   = 8'h00;
		end

		// Lockout and disable override everything
		if (sup_low)
		begin
			n.state     = ST_OFF;
			n.lock_seen = 1'b1;
			n.pg        = 1'b0;
		end
		else if (r.en_cnt == EN_LOW_CYC || !r.ctrl_en)
		begin
			n.state = ST_OFF;
			n.pg    = 1'b0;
		end

		// Switch commands for the coming cycle
		on_lim = (n.ontime < DUTY_MAX_CYC) ? n.ontime : DUTY_MAX_CYC;
		if (n.state == ST_SS && n.ss_lim < on_lim)
			on_lim = n.ss_lim;
		n.hs = (n.state == ST_SS || n.state == ST_RUN) && !n.skip && !n.hs_cut && (n.per < on_lim);
		n.ls = 1'b0;
		if (n.state == ST_RUN)
			n.ls = !n.hs;
		else if (n.state == ST_SS)
			n.ls = !n.hs && (n.hs_fired || n.skip);
		else if (n.state == ST_SHUTDOWN || n.state == ST_REFRESH)
			n.ls = 1'b1;
		else if (n.state == ST_OVP)
			n.ls = (n.neg_cnt == 4'h0) && fb_over;
		n.ref_zero = (n.state == ST_OVP);
	end

	// State register
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			r         <= '0;
			r.ctrl_en <= CTRL_EN_RST;
			r.ontime  <= ONTIME_RST;
		end
		else
			r <= n;
	end

	// Outputs
	assign wb_dat_o            = r.dat;
	assign wb_ack_o            = r.ack;
	assign upper_switch_on_o   = r.hs;
	assign lower_switch_on_o   = r.ls;
	assign reference_zero_o    = r.ref_zero;
	assign soft_start_o        = (r.state == ST_SS);
	assign power_good_out_o    = 1'b0;
	assign power_good_out_oe_o = ~r.pg;

	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	AST_NO_OVERLAP: assert property (!(r.hs && r.ls))
		else $error("both switches on");
	AST_DUTY_CAP: assert property (r.hs |-> r.per < DUTY_MAX_CYC)
		else $error("upper on past duty cap");
	AST_HS_CUT: assert property (r.hs && r.in_s2[IN_ULIM] && r.per != PER_LAST |=> !r.hs)
		else $error("upper limit did not end on-time");
	AST_SHUTDOWN: assert property (r.state == ST_SHUTDOWN |-> r.ls && !r.hs)
		else $error("shutdown switch state wrong");
	AST_HIC_HS: assert property ($rose(r.state == ST_HICCUP) && r.cause == CAUSE_HS |-> r.hic_left == 4'h6 && !r.pg)
		else $error("wrong upper hiccup length");
	AST_LS_SKIP: assert property ((r.state == ST_RUN || r.state == ST_SS) && r.per == PER_LAST
		&& (r.ls_hit || r.in_s2[IN_LLIM]) |=> !r.hs [*8])
		else $error("upper pulse after lower limit");
	AST_UV_DEB: assert property ($rose(r.state == ST_SHUTDOWN) && r.cause == CAUSE_UV
		|-> $past(r.uv_cnt) == UV_LAST && $past(r.armed))
		else $error("undervoltage trip without debounce");
	AST_OVP: assert property (r.state == ST_OVP |-> r.ref_zero && !r.pg && !r.hs)
		else $error("overvoltage outputs wrong");
	AST_NEG_OFF: assert property (r.state == ST_OVP && r.in_s2[IN_NEG] && r.ls && r.hic_left != 4'h1
		|=> !r.ls [*8])
		else $error("lower switch back on too early");
	AST_LOCKOUT: assert property (r.in_s2[IN_SLOW] |=> r.state == ST_OFF && !r.pg && !r.hs)
		else $error("lockout did not shut down");

endmodule
`default_nettype wire

//--- bfhs_pkg.sv
`default_nettype none
package bfhs_pkg;

	// Clock and switching cycle
	localparam int         CLK_MHZ       = 20;
	localparam int         SW_PERIOD_NS  = 1800;
	localparam int         PERIOD_CYC    = SW_PERIOD_NS * CLK_MHZ / 1000;
	localparam logic [5:0] PER_LAST      = 6'(PERIOD_CYC - 1);
	localparam int         DUTY_MAX_PCT  = 80;
	localparam logic [5:0] DUTY_MAX_CYC  = 6'(PERIOD_CYC * DUTY_MAX_PCT / 100);

	// Times in nanoseconds or switching periods and their cycle counts
	localparam int          RST_DELAY_NS  = 100000;
	localparam logic [23:0] RST_LAST      = 24'(RST_DELAY_NS * CLK_MHZ / 1000 - 1);
	localparam int          REFRESH_PER   = 4;
	localparam logic [23:0] REFRESH_LAST  = 24'(REFRESH_PER * PERIOD_CYC - 1);
	localparam int          SS_TIME_NS    = 1000000;
	localparam int          SS_CYC_DEF    = SS_TIME_NS / 1000 * CLK_MHZ;
	localparam int          PG_DELAY_NS   = 100000;
	localparam logic [11:0] PG_DELAY_CYC  = 12'(PG_DELAY_NS * CLK_MHZ / 1000);
	localparam int          UV_DEB_NS     = 2000;
	localparam logic [7:0]  UV_LAST       = 8'(UV_DEB_NS * CLK_MHZ / 1000 - 1);
	localparam int          OV_DEB_NS     = 1000;
	localparam logic [7:0]  OV_LAST       = 8'(OV_DEB_NS * CLK_MHZ / 1000 - 1);
	localparam int          EN_LOW_NS     = 1000;
	localparam logic [7:0]  EN_LOW_CYC    = 8'(EN_LOW_NS * CLK_MHZ / 1000);
	localparam int          NEG_OFF_NS    = 640;
	localparam logic [3:0]  NEG_OFF_CYC   = 4'((NEG_OFF_NS * CLK_MHZ + 999) / 1000);

	// Over-current counters and hiccup lengths in soft-start durations
	localparam logic [3:0] HS_TRIP = 4'h6;
	localparam logic [4:0] LS_TRIP = 5'h08;
	localparam logic [3:0] HIC_HS  = 4'h6;
	localparam logic [3:0] HIC_LS  = 4'h4;
	localparam logic [3:0] HIC_UV  = 4'h5;
	localparam logic [3:0] HIC_OV  = 4'h8;

	// Fault causes
	localparam logic [2:0] CAUSE_NONE = 3'h0;
	localparam logic [2:0] CAUSE_HS   = 3'h1;
	localparam logic [2:0] CAUSE_LS   = 3'h2;
	localparam logic [2:0] CAUSE_UV   = 3'h3;
	localparam logic [2:0] CAUSE_OV   = 3'h4;
	localparam logic [2:0] CAUSE_OT   = 3'h5;

	// Positions of synchronised pin inputs
	localparam int IN_EN = 0, IN_SLOW = 1, IN_SGOOD = 2, IN_ULIM = 3, IN_LLIM = 4, IN_NEG = 5;
	localparam int IN_UNDER = 6, IN_OVER = 7, IN_WIN = 8, IN_ZC = 9, IN_THOT = 10, IN_TREC = 11;
	localparam int IN_PGPIN = 12, NUM_IN = 13;

	// Register map, fields and reset values
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_ONTIME     = 8'h04;
	localparam logic [7:0] REG_STATUS     = 8'h08;
	localparam logic [7:0] REG_COUNT      = 8'h0C;
	localparam int         STAT_PG_BIT    = 4;
	localparam int         STAT_PIN_BIT   = 5;
	localparam int         STAT_CAUSE_LSB = 8;
	localparam int         STAT_LOCK_BIT  = 11;
	localparam int         CNT_LS_LSB     = 8;
	localparam int         CNT_HIC_LSB    = 16;
	localparam logic       CTRL_EN_RST    = 1'b1;
	localparam logic [5:0] ONTIME_RST     = 6'h0C;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_OFF      = 4'h0,
		ST_POST_EN  = 4'h1,
		ST_REFRESH  = 4'h2,
		ST_SS       = 4'h3,
		ST_RUN      = 4'h4,
		ST_SHUTDOWN = 4'h5,
		ST_HICCUP   = 4'h6,
		ST_OVP      = 4'h7,
		ST_THERMAL  = 4'h8
	} bfhs_state_t;

endpackage
`default_nettype wire

//--- bfhs_power_model.sv
`timescale 1ns/1ns
`default_nettype none
module bfhs_power_model (
	// Clock and switch commands
	input  wire logic       clock_i,
	input  wire logic       upper_on_i,
	input  wire logic       lower_on_i,
	// Fault mode: 0 normal, 1 upper, 2 lower, 3 under, 4 over
	input  wire logic [2:0] mode_i,
	// Comparator results
	output logic            upper_lim_o,
	output logic            lower_lim_o,
	output logic            neg_lim_o,
	output logic            fb_under_o,
	output logic            fb_over_o,
	output logic            fb_win_o,
	output logic            zero_cur_o
);
	logic [2:0] low_run_r;
	// Inductor current decays while only the lower switch conducts
	always_ff @(posedge clock_i)
		low_run_r <= (lower_on_i && !upper_on_i) ? ((low_run_r == 3'h7) ? low_run_r : low_run_r + 3'h1) : 3'h0;
	// Comparators follow the switches, so a limit only shows while conducting
	assign upper_lim_o = (mode_i == 3'h1) && upper_on_i;
	assign lower_lim_o = (mode_i == 3'h2) && lower_on_i;
	assign neg_lim_o   = (mode_i == 3'h4) && (low_run_r == 3'h7);
	assign fb_under_o  = (mode_i == 3'h3);
	assign fb_over_o   = (mode_i == 3'h4);
	assign fb_win_o    = (mode_i < 3'h3);
	assign zero_cur_o  = (low_run_r >= 3'h3);
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import bfhs_pkg::*;
	localparam int SS = 360;
	logic        clock_i         = 1'b0;
	logic        rstn_i          = 1'b0;
	logic        cyc             = 1'b0;
	logic        wen             = 1'b0;
	logic [7:0]  adr             = 8'h00;
	logic [31:0] wdat            = 32'h0000_0000;
	logic        en              = 1'b0;
	logic        slow            = 1'b0;
	logic        hot             = 1'b0;
	logic [2:0]  mode            = 3'h0;
	logic [31:0] seed            = 32'h0000_c727;
	int          mismatches      = 0;
	int          samples_checked = 0;
	logic [31:0] rdat;
	logic [31:0] dato;
	logic [31:0] eq[$];
	logic [31:0] mq[$];
	logic        ack, up, lo, rz, pgoe, ulim, llim, neg, fu, fo, fw, zc;
	logic        ss, pgo;
	logic [2:0]  fc[4] = '{CAUSE_HS, CAUSE_LS, CAUSE_UV, CAUSE_OV};
	logic [3:0]  fn[4] = '{HIC_HS, HIC_LS, HIC_UV, HIC_OV};

	bfhs_sequencer #(.SS_CYCLES(SS)) bfhs_sequencer_inst (
		.clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(wen),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
		.enable_i(en), .supply_low_i(slow), .supply_good_i(!slow), .temp_high_i(hot),
		.temp_recovered_i(!hot), .upper_current_limit_i(ulim), .lower_current_limit_i(llim),
		.lower_negative_limit_i(neg), .feedback_under_i(fu), .feedback_over_i(fo),
		.feedback_window_i(fw), .zero_current_detect_i(zc), .upper_switch_on_o(up),
		.lower_switch_on_o(lo), .reference_zero_o(rz), .soft_start_o(ss), .power_good_out_i(!pgoe),
		.power_good_out_o(pgo), .power_good_out_oe_o(pgoe));

	bfhs_power_model bfhs_power_model_inst (
		.clock_i(clock_i), .upper_on_i(up), .lower_on_i(lo), .mode_i(mode), .upper_lim_o(ulim),
		.lower_lim_o(llim), .neg_lim_o(neg), .fb_under_o(fu), .fb_over_o(fo), .fb_win_o(fw),
		.zero_cur_o(zc));

	// Clock
	always #25 clock_i = ~clock_i;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// One classic cycle; reads leave a note with mask and expected value
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, m, e);
		if (!w)
		begin
			eq.push_back(e);
			mq.push_back(m);
		end
		cyc  <= 1'b1;
		wen  <= w;
		adr  <= a;
		wdat <= d;
		do
			@(posedge clock_i);
		while (ack !== 1'b1);
		cyc <= 1'b0;
		@(posedge clock_i);
	endtask

	// Poll STATUS until the masked value matches
	task automatic wst(input logic [31:0] m, v);
		int n;
		n = 0;
		do
		begin
			wb(1'b0, REG_STATUS, 32'h0, 32'h0, 32'h0);
			n++;
		end
		while ((rdat & m) !== v && n < 3000);
		check(rdat & m, v);
	endtask

	// Read answers are matched against the oldest note
	always @(posedge clock_i)
	begin
		if (ack === 1'b1 && !wen && eq.size() > 0)
		begin
			rdat = dato;
			if (mq[0] != 32'h0)
				check(dato & mq[0], eq[0] & mq[0]);
			void'(eq.pop_front());
			void'(mq.pop_front());
		end
	end

	// Watchdog
	initial
	begin
		repeat (90000) @(posedge clock_i);
		mismatches++;
		results();
	end

	initial
	begin
		int nu, nl;
		time t0;
		repeat (12) @(posedge clock_i);
		rstn_i <= 1'b1;
		@(posedge clock_i);
		wb(1'b0, REG_CTRL, 0, 32'h1, 32'(CTRL_EN_RST));
		wb(1'b0, REG_ONTIME, 0, 32'h3F, 32'(ONTIME_RST));
		seed = xs(seed);
		wb(1'b1, 8'h20, seed, 0, 0);
		wb(1'b0, 8'h20, 0, 32'hFFFF_FFFF, 0);
		wb(1'b1, REG_ONTIME, 32'(29 + seed % 35), 0, 0);
		en <= 1'b1;
		wst(32'hF, 32'(ST_RUN));
		check(32'({pgo, ss, pgoe}), 1);
		nu = 0;
		nl = 0;
		repeat (4 * PERIOD_CYC)
		begin
			@(negedge clock_i);
			nu += up;
			nl += lo;
		end
		check(32'(nu), 32'(4 * DUTY_MAX_CYC));
		check(32'(nl), 32'(4 * (PERIOD_CYC - DUTY_MAX_CYC)));
		@(posedge clock_i);
		for (int i = 0; i < 4; i++)
		begin
			wst(32'h10, 32'h10);
			mode <= 3'(i + 1);
			wst(32'hF, 32'((i == 3) ? ST_OVP : ST_HICCUP));
			check(32'(pgoe), 1);
			if (i == 3)
				check(32'({rz, up}), 32'h2);
			wb(1'b0, REG_STATUS, 0, 32'h700, {21'h0, fc[i], 8'h0});
			wb(1'b0, REG_COUNT, 0, 32'hF_0000, {12'h0, fn[i], 16'h0});
			t0 = $time;
			mode <= 3'h0;
			wst(32'hF, 32'(ST_REFRESH));
			nu = int'(($time - t0) / 50) - int'(fn[i]) * SS;
			check(32'(nu > -40 && nu < 20), 1);
		end
		hot <= 1'b1;
		wst(32'hF, 32'(ST_THERMAL));
		check(32'({up, lo, pgoe}), 1);
		hot <= 1'b0;
		wst(32'hF, 32'(ST_SS));
		check(32'(ss), 1);
		slow <= 1'b1;
		wst(32'hF, 32'(ST_OFF));
		check(32'(pgoe), 1);
		wb(1'b0, REG_STATUS, 0, 32'h800, 32'h800);
		slow <= 1'b0;
		wst(32'hF, 32'(ST_REFRESH));
		wst(32'hF, 32'(ST_RUN));
		en <= 1'b0;
		repeat (30) @(posedge clock_i);
		check(32'(pgoe), 1);
		wb(1'b0, REG_STATUS, 0, 32'hF, 32'(ST_OFF));
		results();
	end
endmodule
`default_nettype wire
